/* src/cfl_pkg.sv */
// Constants and types shared by the current foldback limiter
package cfl_pkg;

  // Data widths
  localparam int CUR_W = 16;  // Current magnitude, unsigned counts
  localparam int TIM_W = 24;  // Durations in control strobes
  localparam int SH_W  = 5;   // Decay shift amount
  localparam int ACC_W = CUR_W + TIM_W;

  // Control strobe rate and drive monitoring constants (fixed)
  localparam int STROBE_HZ        = 16000;
  localparam int DRV_PEAK_DUR_MS  = 2000;
  localparam int DRV_DECAY_MS     = 1000;
  localparam int DRV_RECOVERY_MS  = 10000;

  localparam int DRV_PEAK_DUR_N = DRV_PEAK_DUR_MS * (STROBE_HZ / 1000);
  localparam int DRV_DECAY_N    = DRV_DECAY_MS * (STROBE_HZ / 1000);
  localparam int DRV_RECOV_N    = DRV_RECOVERY_MS * (STROBE_HZ / 1000);
  localparam int DRV_SHIFT_N    = $clog2(DRV_DECAY_N);

  localparam logic [TIM_W-1:0] DRV_PEAK_DUR = TIM_W'(DRV_PEAK_DUR_N);
  localparam logic [TIM_W-1:0] DRV_RECOVERY = TIM_W'(DRV_RECOV_N);
  localparam logic [SH_W-1:0]  DRV_SHIFT    = SH_W'(DRV_SHIFT_N);
  localparam logic [CUR_W-1:0] DRV_CONT     = 16'h2000;
  localparam logic [CUR_W-1:0] DRV_PEAK     = 16'h6000;

  // Default fault threshold
  localparam logic [CUR_W-1:0] DEF_FAULT    = 16'h1000;

  // Estimator indices
  localparam int EST_DRV = 0;
  localparam int EST_MOT = 1;
  localparam int EST_NUM = 2;

  // Reset values and unit steps
  localparam logic [CUR_W-1:0] CUR_ZERO = 16'h0000;
  localparam logic [TIM_W-1:0] TIM_ZERO = 24'h000000;
  localparam logic [TIM_W-1:0] TIM_ONE  = 24'h000001;
  localparam logic [CUR_W-1:0] CUR_ONE  = 16'h0001;
  localparam logic [ACC_W-1:0] ACC_ZERO = 40'h00_0000_0000;

  // Estimator phases
  typedef enum logic [1:0] {
    EST_FULL,
    EST_PEAK,
    EST_FOLD,
    EST_RECOVER
  } cfl_phase_e;

endpackage : cfl_pkg

/* src/cfl_limiter.sv */
// Drive and motor thermal current foldback limiter
`timescale 1ns/1ps

// What this block and its software do
// [R1] Drive and motor estimators run in parallel
// [R2] Overall limit is minimum of both limits
// [R3] Foldback further clamps positive/negative peak limits
// [R4] Drive foldback constants are fixed, not ports
// [R5] Above drive continuous, drive limit falls there
// [R6] Drive peak for duration, then exponential decay
// [R7] Drive recovers only below continuous; full time
// [R8] Motor foldback uses coil constant, peak, continuous
// [R9] Motor peak time derived and output
// [R10] After motor peak time, exponential motor decay
// [R11] Limits fall above continuous, rise below it
// [R12] Motor full recovery time; partial current slows
// [R13] Motor or overall below warning level warns
// [R14] Below fault level: fault, power stage off
// [R15] Warning level zero disables warning
// [R16] Software sets warning between fault and limits
// [R17] User fault level only lowers fault threshold
// [R18] Limits, warning and fault set register on strobe; fault clear and stage enable act on any clock
module cfl_limiter (
  input  wire logic                        CLOCK_I,
  input  wire logic                        SRST_I,
  input  wire logic                        STROBE_I,
  input  wire logic [cfl_pkg::CUR_W-1:0]   CURRENT_FB_I,
  input  wire logic [cfl_pkg::CUR_W-1:0]   POSITIVE_PEAK_LIMIT_I,
  input  wire logic [cfl_pkg::CUR_W-1:0]   NEGATIVE_PEAK_LIMIT_I,
  input  wire logic [cfl_pkg::TIM_W-1:0]   COIL_THERMAL_CONSTANT_I,
  input  wire logic [cfl_pkg::CUR_W-1:0]   MOTOR_PEAK_RATING_I,
  input  wire logic [cfl_pkg::CUR_W-1:0]   MOTOR_CONTINUOUS_RATING_I,
  input  wire logic [cfl_pkg::SH_W-1:0]    MOTOR_DECAY_CONSTANT_I,
  input  wire logic [cfl_pkg::TIM_W-1:0]   MOTOR_RECOVERY_TIME_I,
  input  wire logic [cfl_pkg::CUR_W-1:0]   WARNING_LEVEL_I,
  input  wire logic [cfl_pkg::CUR_W-1:0]   USER_FAULT_LEVEL_I,
  input  wire logic                        FAULT_CLEAR_I,
  input  wire logic                        STAGE_ENABLE_I,
  output logic      [cfl_pkg::CUR_W-1:0]   DRIVE_FOLD_LIMIT_O,
  output logic      [cfl_pkg::CUR_W-1:0]   MOTOR_FOLD_LIMIT_O,
  output logic      [cfl_pkg::CUR_W-1:0]   OVERALL_FOLD_LIMIT_O,
  output logic      [cfl_pkg::CUR_W-1:0]   POSITIVE_LIMIT_O,
  output logic      [cfl_pkg::CUR_W-1:0]   NEGATIVE_LIMIT_O,
  output logic      [cfl_pkg::TIM_W-1:0]   MOTOR_PEAK_DURATION_O,
  output logic      [cfl_pkg::CUR_W-1:0]   FAULT_THRESHOLD_O,
  output logic                             FOLDBACK_WARNING_O,
  output logic                             FOLDBACK_FAULT_O,
  output logic                             POWER_STAGE_EN_O
);
  import cfl_pkg::*;

  // Smaller of two currents
  function automatic logic [CUR_W-1:0] cur_min(
    input logic [CUR_W-1:0] a,
    input logic [CUR_W-1:0] b
  );
    cur_min = (a < b) ? a : b;
  endfunction : cur_min

  // One exponential step of lim toward tgt, at least one count unless lim already equals tgt
  function automatic logic [CUR_W-1:0] exp_step(
    input logic [CUR_W-1:0] lim,
    input logic [CUR_W-1:0] tgt,
    input logic [SH_W-1:0]  sh
  );
    logic [CUR_W-1:0] gap;
    logic [CUR_W-1:0] stp;
    gap = (lim > tgt) ? (lim - tgt) : (tgt - lim);
    stp = gap >> sh;
    if (stp == CUR_ZERO)
    begin
      stp = (gap == CUR_ZERO) ? CUR_ZERO : CUR_ONE;
    end
    exp_step = (lim > tgt) ? (lim - stp) : (lim + stp);
  endfunction : exp_step

  // Peak time from coil constant scaled by (cont/peak)^2
  function automatic logic [TIM_W-1:0] peak_time(
    input logic [TIM_W-1:0] tau,
    input logic [CUR_W-1:0] pk,
    input logic [CUR_W-1:0] ct
  );
    logic [2*CUR_W-1:0]       pk2;
    logic [2*CUR_W+TIM_W-1:0] num;
    logic [2*CUR_W+TIM_W-1:0] q;
    pk2 = (2*CUR_W)'(pk) * (2*CUR_W)'(pk);
    num = (2*CUR_W+TIM_W)'(tau) *
          (2*CUR_W+TIM_W)'((2*CUR_W)'(ct) * (2*CUR_W)'(ct));
    q   = (pk2 == '0) ? '0 : num / (2*CUR_W+TIM_W)'(pk2);
    peak_time = (q > (2*CUR_W+TIM_W)'(tau)) ? tau : q[TIM_W-1:0];
  endfunction : peak_time

  // Parameter sets; drive set comes from fixed constants only
  logic [CUR_W-1:0] peak_v [EST_NUM];
  logic [CUR_W-1:0] cont_v [EST_NUM];
  logic [TIM_W-1:0] dur_v  [EST_NUM];
  logic [TIM_W-1:0] rec_v  [EST_NUM];
  logic [SH_W-1:0]  sh_v   [EST_NUM];

  // Estimator state
  cfl_phase_e       ph_q   [EST_NUM];
  cfl_phase_e       ph_d   [EST_NUM];
  logic [CUR_W-1:0] lim_q  [EST_NUM];
  logic [CUR_W-1:0] lim_d  [EST_NUM];
  logic [TIM_W-1:0] used_q [EST_NUM];
  logic [TIM_W-1:0] used_d [EST_NUM];
  logic [ACC_W-1:0] rec_q  [EST_NUM];
  logic [ACC_W-1:0] rec_d  [EST_NUM];

  logic [TIM_W-1:0] mot_dur_d;
  logic [CUR_W-1:0] overall_d;
  logic [CUR_W-1:0] fault_thr_d;
  logic             warn_d;
  logic             fault_hit_d;

  // Parameter selection per estimator
  always_comb
  begin
    peak_v[EST_DRV] = DRV_PEAK;                          // [R4]
    cont_v[EST_DRV] = DRV_CONT;
    dur_v[EST_DRV]  = DRV_PEAK_DUR;
    rec_v[EST_DRV]  = DRV_RECOVERY;
    sh_v[EST_DRV]   = DRV_SHIFT;
    peak_v[EST_MOT] = MOTOR_PEAK_RATING_I;               // [R8]
    cont_v[EST_MOT] = MOTOR_CONTINUOUS_RATING_I;
    dur_v[EST_MOT]  = mot_dur_d;
    rec_v[EST_MOT]  = MOTOR_RECOVERY_TIME_I;
    sh_v[EST_MOT]   = MOTOR_DECAY_CONSTANT_I;
  end

  // Motor peak duration derived from coil constant and ratings
  assign mot_dur_d = peak_time(COIL_THERMAL_CONSTANT_I,
                               MOTOR_PEAK_RATING_I,
                               MOTOR_CONTINUOUS_RATING_I);  // [R9]

  // Both estimators share one next-state description
  always_comb
  begin
    for (int k = 0; k < EST_NUM; k++)                      // [R1]
    begin
      ph_d[k]   = ph_q[k];
      lim_d[k]  = lim_q[k];
      used_d[k] = used_q[k];
      rec_d[k]  = rec_q[k];
      case (ph_q[k])
        EST_FULL:
        begin
          lim_d[k] = peak_v[k];
          if (CURRENT_FB_I > cont_v[k])
          begin
            ph_d[k]   = EST_PEAK;
            used_d[k] = TIM_ONE;
          end
        end
        EST_PEAK:
        begin
          lim_d[k] = peak_v[k];                            // [R6]
          if (CURRENT_FB_I <= cont_v[k])
          begin
            ph_d[k]  = EST_RECOVER;
            rec_d[k] = ACC_ZERO;
          end
          else if (used_q[k] >= dur_v[k])
          begin
            ph_d[k] = EST_FOLD;                            // [R10]
          end
          else
          begin
            used_d[k] = used_q[k] + TIM_ONE;
          end
        end
        EST_FOLD:
        begin
          if (CURRENT_FB_I > cont_v[k])
          begin
            // Decays to, never below, continuous
            lim_d[k] = exp_step(lim_q[k], cont_v[k],
                                sh_v[k]);             // [R5] [R6] [R10] [R11]
          end
          else
          begin
            ph_d[k]  = EST_RECOVER;
            rec_d[k] = ACC_ZERO;
          end
        end
        EST_RECOVER:
        begin
          if (CURRENT_FB_I > cont_v[k])
          begin
            // Recovery count restarts from zero; limit steps on toward continuous, spent peak time is kept
            ph_d[k]  = EST_FOLD;
            rec_d[k] = ACC_ZERO;
            lim_d[k] = exp_step(lim_q[k], cont_v[k], sh_v[k]); // [R11]
          end
          else
          begin
            lim_d[k] = exp_step(lim_q[k], peak_v[k], sh_v[k]); // [R11]
            rec_d[k] = rec_q[k] +
                       ACC_W'(cont_v[k] - CURRENT_FB_I);    // [R7] [R12]
            // Both factors widened first so the product keeps all bits
            if (rec_d[k] >=
                ACC_W'(cont_v[k]) * ACC_W'(rec_v[k]))       // [R7] [R12]
            begin
              ph_d[k]   = EST_FULL;
              lim_d[k]  = peak_v[k];
              used_d[k] = TIM_ZERO;
              rec_d[k]  = ACC_ZERO;
            end
          end
        end
        default:
        begin
          ph_d[k] = EST_FULL;
        end
      endcase
    end
  end

  // Overall limit and threshold comparisons on the new limits
  always_comb
  begin
    overall_d = cur_min(lim_d[EST_DRV], lim_d[EST_MOT]);   // [R2]
    // Zero user level means unset; higher than default is ignored
    fault_thr_d = DEF_FAULT;
    if (USER_FAULT_LEVEL_I != CUR_ZERO &&
        USER_FAULT_LEVEL_I < DEF_FAULT)
    begin
      fault_thr_d = USER_FAULT_LEVEL_I;                    // [R17]
    end
    warn_d = (WARNING_LEVEL_I != CUR_ZERO) &&              // [R15]
             ((lim_d[EST_MOT] < WARNING_LEVEL_I) ||
              (overall_d < WARNING_LEVEL_I));              // [R13]
    fault_hit_d = (lim_d[EST_MOT] < fault_thr_d) ||
                  (overall_d < fault_thr_d);               // [R14]
  end

  // Estimator registers, advanced only on the control strobe
  always_ff @(posedge CLOCK_I)
  begin
    for (int k = 0; k < EST_NUM; k++)
    begin
      if (SRST_I)
      begin
        ph_q[k]   <= EST_FULL;
        lim_q[k]  <= CUR_ZERO;
        used_q[k] <= TIM_ZERO;
        rec_q[k]  <= ACC_ZERO;
      end
      else if (STROBE_I)                                   // [R18]
      begin
        ph_q[k]   <= ph_d[k];
        lim_q[k]  <= lim_d[k];
        used_q[k] <= used_d[k];
        rec_q[k]  <= rec_d[k];
      end
    end
  end

  // Limit outputs; foldback clamps the instantaneous peak limits
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      DRIVE_FOLD_LIMIT_O    <= CUR_ZERO;
      MOTOR_FOLD_LIMIT_O    <= CUR_ZERO;
      OVERALL_FOLD_LIMIT_O  <= CUR_ZERO;
      POSITIVE_LIMIT_O      <= CUR_ZERO;
      NEGATIVE_LIMIT_O      <= CUR_ZERO;
      MOTOR_PEAK_DURATION_O <= TIM_ZERO;
      FAULT_THRESHOLD_O     <= DEF_FAULT;
    end
    else if (STROBE_I)                                     // [R18]
    begin
      DRIVE_FOLD_LIMIT_O    <= lim_d[EST_DRV];
      MOTOR_FOLD_LIMIT_O    <= lim_d[EST_MOT];
      OVERALL_FOLD_LIMIT_O  <= overall_d;                  // [R2]
      POSITIVE_LIMIT_O      <= cur_min(POSITIVE_PEAK_LIMIT_I,
                                       overall_d);         // [R3]
      NEGATIVE_LIMIT_O      <= cur_min(NEGATIVE_PEAK_LIMIT_I,
                                       overall_d);         // [R3]
      MOTOR_PEAK_DURATION_O <= mot_dur_d;                  // [R9]
      FAULT_THRESHOLD_O     <= fault_thr_d;
    end
  end

  // Warning is a level that follows the comparison each strobe
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      FOLDBACK_WARNING_O <= 1'b0;
    end
    else if (STROBE_I)
    begin
      FOLDBACK_WARNING_O <= warn_d;                        // [R13] [R18]
    end
  end

  // Fault is sticky; a new hit wins over a clear in the same cycle
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      FOLDBACK_FAULT_O <= 1'b0;
    end
    else if (STROBE_I && fault_hit_d)
    begin
      FOLDBACK_FAULT_O <= 1'b1;                            // [R14] [R18]
    end
    else if (FAULT_CLEAR_I)
    begin
      FOLDBACK_FAULT_O <= 1'b0;
    end
  end

  // Power stage off while faulted, so the load coasts
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      POWER_STAGE_EN_O <= 1'b0;
    end
    else
    begin
      POWER_STAGE_EN_O <= STAGE_ENABLE_I && !FOLDBACK_FAULT_O &&
                          !(STROBE_I && fault_hit_d);      // [R14]
    end
  end

endmodule : cfl_limiter

/* verif/cfl_limiter_assertions.sv */
// Port-level checker for the current foldback limiter
`timescale 1ns/1ps
module cfl_limiter_chk (
  input wire logic                      CLOCK_I,
  input wire logic                      SRST_I,
  input wire logic                      STROBE_I,
  input wire logic                      STAGE_ENABLE_I,
  input wire logic [cfl_pkg::CUR_W-1:0] WARNING_LEVEL_I,
  input wire logic [cfl_pkg::CUR_W-1:0] USER_FAULT_LEVEL_I,
  input wire logic [cfl_pkg::CUR_W-1:0] DRIVE_FOLD_LIMIT_O,
  input wire logic [cfl_pkg::CUR_W-1:0] MOTOR_FOLD_LIMIT_O,
  input wire logic [cfl_pkg::CUR_W-1:0] OVERALL_FOLD_LIMIT_O,
  input wire logic [cfl_pkg::CUR_W-1:0] FAULT_THRESHOLD_O,
  input wire logic                      FOLDBACK_WARNING_O,
  input wire logic                      FOLDBACK_FAULT_O,
  input wire logic                      POWER_STAGE_EN_O
);
  import cfl_pkg::*;
  logic [CUR_W-1:0] min_lim;
  logic [CUR_W-1:0] thr_exp;
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SRST_I);
  // Expected minimum and effective threshold; user level only lowers it
  assign min_lim = (DRIVE_FOLD_LIMIT_O < MOTOR_FOLD_LIMIT_O) ?
                   DRIVE_FOLD_LIMIT_O : MOTOR_FOLD_LIMIT_O;
  assign thr_exp = (USER_FAULT_LEVEL_I != CUR_ZERO &&
                    USER_FAULT_LEVEL_I < DEF_FAULT) ?
                   USER_FAULT_LEVEL_I : DEF_FAULT;
  a_overall_min:
    assert property (OVERALL_FOLD_LIMIT_O == min_lim)
    else $error("overall limit is not the minimum");
  a_drive_cap:
    assert property (DRIVE_FOLD_LIMIT_O <= DRV_PEAK)
    else $error("drive limit above fixed peak");
  a_fault_hit:
    assert property (STROBE_I ##1 (OVERALL_FOLD_LIMIT_O < FAULT_THRESHOLD_O)
                     |-> FOLDBACK_FAULT_O)
    else $error("limit below threshold without fault");
  a_stage_follow:
    assert property (!$past(SRST_I) && !$past(FOLDBACK_FAULT_O) &&
                     $past(STAGE_ENABLE_I) && !FOLDBACK_FAULT_O
                     |-> POWER_STAGE_EN_O)
    else $error("power stage off without fault");
  a_warn_zero:
    assert property (STROBE_I && WARNING_LEVEL_I == CUR_ZERO
                     |=> !FOLDBACK_WARNING_O)
    else $error("warning raised with level zero");
  a_warn_hit:
    assert property (STROBE_I ##1 (WARNING_LEVEL_I != CUR_ZERO &&
                     OVERALL_FOLD_LIMIT_O < WARNING_LEVEL_I)
                     |-> FOLDBACK_WARNING_O)
    else $error("limit below warning level without warning");
  a_thr_pick:
    assert property ($past(STROBE_I) |-> FAULT_THRESHOLD_O == $past(thr_exp))
    else $error("wrong effective fault threshold");
  a_hold_still:
    assert property (!STROBE_I |=> $stable(OVERALL_FOLD_LIMIT_O) &&
                     $stable(FOLDBACK_WARNING_O))
    else $error("limit or warning moved without strobe");
  c_fault: cover property ($rose(FOLDBACK_FAULT_O));
  c_warn: cover property ($rose(FOLDBACK_WARNING_O));
  c_clear: cover property ($fell(FOLDBACK_FAULT_O));
endmodule : cfl_limiter_chk

/* verif/cfl_loop_model.sv */
// Current loop and power stage model feeding current back
`timescale 1ns/1ps
module cfl_loop_model (
  input  wire logic                      clk_i,
  input  wire logic                      slow_i,
  input  wire logic                      stage_en_i,
  input  wire logic [cfl_pkg::CUR_W-1:0] demand_i,
  output logic      [cfl_pkg::CUR_W-1:0] current_o
);
  import cfl_pkg::*;
  logic [CUR_W-1:0] now_cur;
  logic [CUR_W-1:0] lag_q;
  // Disabled stage coasts, so no current flows
  assign now_cur = stage_en_i ? demand_i : CUR_ZERO;
  // Slow loop settles one clock late
  always_ff @(posedge clk_i)
  begin
    lag_q <= now_cur;
  end
  assign current_o = slow_i ? lag_q : now_cur;
endmodule : cfl_loop_model

/* verif/cfl_limiter_tb_top.sv */
// Self-checking bench for the current foldback limiter
`timescale 1ns/1ps
module cfl_limiter_tb_top;
  import cfl_pkg::*;
  logic             CLOCK_I = 1'b0;
  logic             SRST_I, STROBE_I, FAULT_CLEAR_I, slow;
  logic             STAGE_ENABLE_I, FOLDBACK_WARNING_O, FOLDBACK_FAULT_O;
  logic             POWER_STAGE_EN_O;
  logic [CUR_W-1:0] CURRENT_FB_I, POSITIVE_PEAK_LIMIT_I, NEGATIVE_PEAK_LIMIT_I;
  logic [CUR_W-1:0] MOTOR_PEAK_RATING_I, MOTOR_CONTINUOUS_RATING_I, demand;
  logic [CUR_W-1:0] WARNING_LEVEL_I, USER_FAULT_LEVEL_I, DRIVE_FOLD_LIMIT_O;
  logic [CUR_W-1:0] MOTOR_FOLD_LIMIT_O, OVERALL_FOLD_LIMIT_O, POSITIVE_LIMIT_O;
  logic [CUR_W-1:0] NEGATIVE_LIMIT_O, FAULT_THRESHOLD_O;
  logic [TIM_W-1:0] COIL_THERMAL_CONSTANT_I, MOTOR_RECOVERY_TIME_I;
  logic [TIM_W-1:0] MOTOR_PEAK_DURATION_O;
  logic [SH_W-1:0]  MOTOR_DECAY_CONSTANT_I;
  int               err_total, checked, cycles;
  // Threshold cases: lower user level taken, higher and zero ignored
  logic [CUR_W-1:0] ufl [3] = '{16'h0800, 16'h1800, 16'h0000};
  logic [CUR_W-1:0] thr [3] = '{16'h0800, 16'h1000, 16'h1000};
  cfl_limiter dut (
    .CLOCK_I                   (CLOCK_I),
    .SRST_I                    (SRST_I),
    .STROBE_I                  (STROBE_I),
    .CURRENT_FB_I              (CURRENT_FB_I),
    .POSITIVE_PEAK_LIMIT_I     (POSITIVE_PEAK_LIMIT_I),
    .NEGATIVE_PEAK_LIMIT_I     (NEGATIVE_PEAK_LIMIT_I),
    .COIL_THERMAL_CONSTANT_I   (COIL_THERMAL_CONSTANT_I),
    .MOTOR_PEAK_RATING_I       (MOTOR_PEAK_RATING_I),
    .MOTOR_CONTINUOUS_RATING_I (MOTOR_CONTINUOUS_RATING_I),
    .MOTOR_DECAY_CONSTANT_I    (MOTOR_DECAY_CONSTANT_I),
    .MOTOR_RECOVERY_TIME_I     (MOTOR_RECOVERY_TIME_I),
    .WARNING_LEVEL_I           (WARNING_LEVEL_I),
    .USER_FAULT_LEVEL_I        (USER_FAULT_LEVEL_I),
    .FAULT_CLEAR_I             (FAULT_CLEAR_I),
    .STAGE_ENABLE_I            (STAGE_ENABLE_I),
    .DRIVE_FOLD_LIMIT_O        (DRIVE_FOLD_LIMIT_O),
    .MOTOR_FOLD_LIMIT_O        (MOTOR_FOLD_LIMIT_O),
    .OVERALL_FOLD_LIMIT_O      (OVERALL_FOLD_LIMIT_O),
    .POSITIVE_LIMIT_O          (POSITIVE_LIMIT_O),
    .NEGATIVE_LIMIT_O          (NEGATIVE_LIMIT_O),
    .MOTOR_PEAK_DURATION_O     (MOTOR_PEAK_DURATION_O),
    .FAULT_THRESHOLD_O         (FAULT_THRESHOLD_O),
    .FOLDBACK_WARNING_O        (FOLDBACK_WARNING_O),
    .FOLDBACK_FAULT_O          (FOLDBACK_FAULT_O),
    .POWER_STAGE_EN_O          (POWER_STAGE_EN_O)
  );
  cfl_loop_model loop (.clk_i(CLOCK_I), .slow_i(slow),
    .stage_en_i(POWER_STAGE_EN_O), .demand_i(demand), .current_o(CURRENT_FB_I));
  // 200 MHz clock
  always #2.5 CLOCK_I = ~CLOCK_I;
  task automatic cmp(input string n, input logic [TIM_W-1:0] e, g);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  // Strobes on n back-to-back clocks, then lets outputs settle
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge CLOCK_I);
      #1 STROBE_I = 1'b1;
    end
    @(posedge CLOCK_I);
    #1 STROBE_I = 1'b0;
    @(posedge CLOCK_I);
    #1;
  endtask : pulse
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // Hang guard, far above the roughly 770 cycles the tests need
  always @(posedge CLOCK_I)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      err_total++;
      report_and_stop();
    end
  end
  initial
  begin
    {STROBE_I, FAULT_CLEAR_I, slow} = 3'h0;
    {SRST_I, STAGE_ENABLE_I} = 2'h3;
    {POSITIVE_PEAK_LIMIT_I, NEGATIVE_PEAK_LIMIT_I} = {16'h4000, 16'h7000};
    {MOTOR_PEAK_RATING_I, MOTOR_CONTINUOUS_RATING_I} = {16'h5000, 16'h2800};
    {WARNING_LEVEL_I, USER_FAULT_LEVEL_I, demand} = {3{16'h0000}};
    COIL_THERMAL_CONSTANT_I = 24'h000400;
    MOTOR_RECOVERY_TIME_I = 24'h000064;
    MOTOR_DECAY_CONSTANT_I = 5'h02;
    repeat (6) @(posedge CLOCK_I);
    #1 SRST_I = 1'b0;
    cmp("overall", CUR_ZERO, OVERALL_FOLD_LIMIT_O);
    cmp("threshold", DEF_FAULT, FAULT_THRESHOLD_O);
    pulse(1);
    cmp("drive", DRV_PEAK, DRIVE_FOLD_LIMIT_O);
    cmp("motor", 16'h5000, MOTOR_FOLD_LIMIT_O);
    cmp("overall", 16'h5000, OVERALL_FOLD_LIMIT_O);
    cmp("positive", 16'h4000, POSITIVE_LIMIT_O);
    cmp("negative", 16'h5000, NEGATIVE_LIMIT_O);
    cmp("peak time", 24'h000100, MOTOR_PEAK_DURATION_O);
    $display("test load done");
    for (int i = 0; i < 3; i++)
    begin
      USER_FAULT_LEVEL_I = ufl[i];
      pulse(1);
      cmp("threshold", thr[i], FAULT_THRESHOLD_O);
    end
    $display("test threshold done");
    // Warning level between fault level and the present limits
    {demand, slow, WARNING_LEVEL_I} = {16'h3000, 1'b1, 16'h3000};
    pulse(200);
    cmp("motor", 16'h5000, MOTOR_FOLD_LIMIT_O);
    cmp("warning", 1'b0, FOLDBACK_WARNING_O);
    pulse(400);
    cmp("drive", DRV_PEAK, DRIVE_FOLD_LIMIT_O);
    cmp("motor", 16'h2800, MOTOR_FOLD_LIMIT_O);
    cmp("overall", 16'h2800, OVERALL_FOLD_LIMIT_O);
    cmp("warning", 1'b1, FOLDBACK_WARNING_O);
    WARNING_LEVEL_I = 16'h0000;
    pulse(1);
    cmp("warning", 1'b0, FOLDBACK_WARNING_O);
    $display("test fold done");
    {MOTOR_CONTINUOUS_RATING_I, slow} = {16'h0800, 1'b0};
    pulse(130);
    cmp("fault", 1'b1, FOLDBACK_FAULT_O);
    cmp("stage", 1'b0, POWER_STAGE_EN_O);
    cmp("motor", 16'h5000, MOTOR_FOLD_LIMIT_O);
    {demand, FAULT_CLEAR_I} = {16'h0000, 1'b1};
    pulse(1);
    FAULT_CLEAR_I = 1'b0;
    pulse(1);
    cmp("fault", 1'b0, FOLDBACK_FAULT_O);
    cmp("stage", 1'b1, POWER_STAGE_EN_O);
    $display("test fault done");
    SRST_I = 1'b1;
    repeat (2) @(posedge CLOCK_I);
    #1 SRST_I = 1'b0;
    cmp("motor", CUR_ZERO, MOTOR_FOLD_LIMIT_O);
    $display("test reset done");
    report_and_stop();
  end
endmodule : cfl_limiter_tb_top
bind cfl_limiter cfl_limiter_chk chk (
  .CLOCK_I              (CLOCK_I),
  .SRST_I               (SRST_I),
  .STROBE_I             (STROBE_I),
  .STAGE_ENABLE_I       (STAGE_ENABLE_I),
  .WARNING_LEVEL_I      (WARNING_LEVEL_I),
  .USER_FAULT_LEVEL_I   (USER_FAULT_LEVEL_I),
  .DRIVE_FOLD_LIMIT_O   (DRIVE_FOLD_LIMIT_O),
  .MOTOR_FOLD_LIMIT_O   (MOTOR_FOLD_LIMIT_O),
  .OVERALL_FOLD_LIMIT_O (OVERALL_FOLD_LIMIT_O),
  .FAULT_THRESHOLD_O    (FAULT_THRESHOLD_O),
  .FOLDBACK_WARNING_O   (FOLDBACK_WARNING_O),
  .FOLDBACK_FAULT_O     (FOLDBACK_FAULT_O),
  .POWER_STAGE_EN_O     (POWER_STAGE_EN_O)
);
